// ===== logic/fsi_integrity.sv
`timescale 1ns/10ps
`include "fsi_defines.svh"

// Functional notes
// - rerun the otp crc check every 5 ms while running
// - otp crc mismatch sets sticky flag bit 19, cleared by writing one
// - every init register is compared constantly with its inverted shadow
// - any shadow mismatch sets sticky flag bit 16, cleared by writing one
// - bits 12..8 show the live fail-safe state, init state 0 0110
// - write-one-to-clear flags also clear on power-on reset
module fsi_integrity #(
  parameter int OTP_DEPTH         = `FSI_OTP_DEPTH,
  parameter int INIT_REGS         = `FSI_INIT_REGS,
  parameter int CRC_PERIOD_CYCLES = `FSI_CRC_PERIOD_CYC
) (
  input  wire logic                          clk,
  input  wire logic                          reset,
  input  wire logic                          ce,
  input  wire logic                          regWrEn,
  input  wire logic [`FSI_REG_WIDTH-1:0]     regWrData,
  output logic      [`FSI_REG_WIDTH-1:0]     regRdData,
  input  wire logic [`FSI_STATE_WIDTH-1:0]   safety_a,
  input  wire logic                          debugEnter,
  output logic                               debugActive,
  output logic                               leaveDebugPulse,
  input  wire logic [INIT_REGS*8-1:0]        init_reg_true_copy,
  input  wire logic [INIT_REGS*8-1:0]        init_reg_inverted_copy,
  input  wire logic                          otpWrEn,
  input  wire logic [$clog2(OTP_DEPTH)-1:0]  otpWrAddr,
  input  wire logic [7:0]                    otpWrData,
  input  wire logic [7:0]                    otpCrcExpected,
  output logic                               otpCheckDone
);

  localparam int AW = $clog2(OTP_DEPTH);
  localparam int TW = $clog2(CRC_PERIOD_CYCLES + 1);

  // --------------------------------------------------------------------
  // elaboration checks
  // --------------------------------------------------------------------
  if (OTP_DEPTH < 2 || INIT_REGS < 1)
  begin : g_bad_size
    $error("fsi_integrity: otp depth and init register count too small");
  end
  if (CRC_PERIOD_CYCLES < OTP_DEPTH + 4)
  begin : g_bad_period
    $error("fsi_integrity: crc period shorter than one otp walk");
  end

  typedef struct packed {
    fsi_pkg::fsi_scan_t        scan;
    logic [TW-1:0]             timer;
    logic [AW-1:0]             addr;
    logic                      lastIssued;
    logic                      dataValid;
    logic [7:0]                crc;
    logic                      otpErr;
    logic                      regErr;
    logic                      debug;
    logic                      leavePulse;
    logic                      done;
    logic [`FSI_REG_WIDTH-1:0] rdData;
  } fsi_state_t;

  fsi_state_t state_reg;
  fsi_state_t state_next;

  logic [7:0]  otpRdData;
  logic        shadowBad;
  logic        wrLeave;
  logic        wrClrOtp;
  logic        wrClrReg;

  // --------------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------------
  // register bit number to data word index
  function automatic int fsi_pos(input int regBit);
    return regBit - `FSI_REG_LSB;
  endfunction : fsi_pos

  // one byte of crc-8, msb first
  function automatic logic [7:0] fsi_crc8(input logic [7:0] crcIn, input logic [7:0] data);
    logic [7:0] c;
    c = crcIn ^ data;
    for (int i = 0; i < 8; i++)
    begin
      c = c[7] ? ((c << 1) ^ `FSI_CRC_POLY) : (c << 1);
    end
    return c;
  endfunction : fsi_crc8

  // --------------------------------------------------------------------
  // otp image store
  // --------------------------------------------------------------------
  fsi_otp_mem #(
    .WIDTH (8),
    .DEPTH (OTP_DEPTH)
  ) u_otp (
    .clk    (clk),
    .reset  (reset),
    .ce     (ce),
    .wrEn   (otpWrEn),
    .wrAddr (otpWrAddr),
    .wrData (otpWrData),
    .rdAddr (state_reg.addr),
    .rdData (otpRdData)
  );

  // --------------------------------------------------------------------
  // shadow compare and write decode
  // --------------------------------------------------------------------
  assign shadowBad = (init_reg_true_copy != ~init_reg_inverted_copy);
  assign wrLeave   = regWrEn & regWrData[fsi_pos(`FSI_LEAVE_DBG_BIT)];
  assign wrClrOtp  = regWrEn & regWrData[fsi_pos(`FSI_OTP_ERR_BIT)];
  assign wrClrReg  = regWrEn & regWrData[fsi_pos(`FSI_REG_ERR_BIT)];

  // --------------------------------------------------------------------
  // next state
  // --------------------------------------------------------------------
  always_comb
  begin
    logic otpMismatch;
    otpMismatch           = 1'b0;
    state_next            = state_reg;
    state_next.leavePulse = 1'b0;
    state_next.done       = 1'b0;

    // period timer runs regardless of walk phase, so spacing stays fixed
    if (state_reg.timer == TW'(CRC_PERIOD_CYCLES - 1))
    begin
      state_next.timer = '0;
    end
    else
    begin
      state_next.timer = state_reg.timer + TW'(1);
    end

    // otp walk: address issued one cycle, data arrives the next
    state_next.dataValid = 1'b0;
    unique case (state_reg.scan)
      fsi_pkg::SCAN_IDLE:
      begin
        if (state_reg.timer == TW'(CRC_PERIOD_CYCLES - 1))
        begin
          state_next.scan       = fsi_pkg::SCAN_READ;
          state_next.addr       = '0;
          state_next.crc        = `FSI_CRC_SEED;
          state_next.lastIssued = 1'b0;
        end
      end
      fsi_pkg::SCAN_READ:
      begin
        state_next.dataValid = ~state_reg.lastIssued;
        if (state_reg.dataValid)
        begin
          state_next.crc = fsi_crc8(state_reg.crc, otpRdData);
        end
        if (state_reg.addr == AW'(OTP_DEPTH - 1))
        begin
          state_next.lastIssued = 1'b1;
        end
        else
        begin
          state_next.addr = state_reg.addr + AW'(1);
        end
        if (state_reg.lastIssued && !state_reg.dataValid)
        begin
          state_next.scan = fsi_pkg::SCAN_DONE;
        end
      end
      fsi_pkg::SCAN_DONE:
      begin
        otpMismatch     = (state_reg.crc != otpCrcExpected);
        state_next.done = 1'b1;
        state_next.scan = fsi_pkg::SCAN_IDLE;
        state_next.addr = '0;
      end
    endcase

    // sticky flags: a new error in the clearing cycle wins
    if (otpMismatch)
    begin
      state_next.otpErr = 1'b1;
    end
    else if (wrClrOtp)
    begin
      state_next.otpErr = 1'b0;
    end
    if (shadowBad)
    begin
      state_next.regErr = 1'b1;
    end
    else if (wrClrReg)
    begin
      state_next.regErr = 1'b0;
    end

    // debug mode: leave command beats a simultaneous entry request
    if (wrLeave)
    begin
      state_next.debug      = 1'b0;
      state_next.leavePulse = state_reg.debug;
    end
    else if (debugEnter)
    begin
      state_next.debug = 1'b1;
    end

    // read image, reserved bits zero
    state_next.rdData = '0;
    state_next.rdData[fsi_pos(`FSI_DBG_ACTIVE_BIT)] = state_next.debug;
    state_next.rdData[fsi_pos(`FSI_OTP_ERR_BIT)]    = state_next.otpErr;
    state_next.rdData[fsi_pos(`FSI_REG_ERR_BIT)]    = state_next.regErr;
    state_next.rdData[fsi_pos(`FSI_STATE_MSB):fsi_pos(`FSI_STATE_LSB)] = safety_a;
  end

  // --------------------------------------------------------------------
  // registers
  // --------------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      state_reg        <= '0;
      state_reg.scan   <= fsi_pkg::SCAN_IDLE;
      state_reg.crc    <= `FSI_CRC_SEED;
      state_reg.rdData <= `FSI_RESET_VALUE; // init state shown
    end
    else if (ce)
    begin
      state_reg <= state_next;
    end
  end

  // --------------------------------------------------------------------
  // outputs
  // --------------------------------------------------------------------
  assign regRdData       = state_reg.rdData;
  assign debugActive     = state_reg.debug;
  assign leaveDebugPulse = state_reg.leavePulse;
  assign otpCheckDone    = state_reg.done;

endmodule : fsi_integrity

// ===== logic/fsi_defines.svh
`ifndef FSI_DEFINES_SVH
`define FSI_DEFINES_SVH

// ----------------------------------------------------------------------
// register layout (register bit numbers; data word bit 0 = register bit 8)
// ----------------------------------------------------------------------
`define FSI_REG_LSB         8
`define FSI_REG_WIDTH       16
`define FSI_LEAVE_DBG_BIT   22
`define FSI_DBG_ACTIVE_BIT  21
`define FSI_OTP_ERR_BIT     19
`define FSI_REG_ERR_BIT     16
`define FSI_STATE_MSB       12
`define FSI_STATE_LSB       8
`define FSI_STATE_WIDTH     5
`define FSI_STATE_INIT      5'h06
`define FSI_RESET_VALUE     16'h0006

// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define FSI_CLK_HZ          20000000
`define FSI_CRC_PERIOD_US   5000
`define FSI_CRC_PERIOD_CYC  ((`FSI_CRC_PERIOD_US * (`FSI_CLK_HZ / 1000)) / 1000)

// ----------------------------------------------------------------------
// otp check
// ----------------------------------------------------------------------
`define FSI_CRC_POLY        8'h2F
`define FSI_CRC_SEED        8'hFF
`define FSI_OTP_DEPTH       32
`define FSI_INIT_REGS       4

`endif

// ===== logic/fsi_pkg.sv
package fsi_pkg;

  // one-hot phases of the otp check walk
  typedef enum logic [2:0] {
    SCAN_IDLE = 3'b001,
    SCAN_READ = 3'b010,
    SCAN_DONE = 3'b100
  } fsi_scan_t;

endpackage : fsi_pkg

// ===== logic/fsi_otp_mem.sv
`timescale 1ns/10ps

// small otp image store: one write port, registered read data
module fsi_otp_mem #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  input  wire logic                     clk,
  input  wire logic                     reset,
  input  wire logic                     ce,
  input  wire logic                     wrEn,
  input  wire logic [$clog2(DEPTH)-1:0] wrAddr,
  input  wire logic [WIDTH-1:0]         wrData,
  input  wire logic [$clog2(DEPTH)-1:0] rdAddr,
  output logic      [WIDTH-1:0]         rdData
);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] cells;
    logic [WIDTH-1:0]            rdData;
  } fsi_mem_state_t;

  fsi_mem_state_t state_reg;
  fsi_mem_state_t state_next;

  // --------------------------------------------------------------------
  // next state
  // --------------------------------------------------------------------
  always_comb
  begin
    state_next        = state_reg;
    state_next.rdData = state_reg.cells[rdAddr];
    if (wrEn)
    begin
      state_next.cells[wrAddr] = wrData;
    end
  end

  // --------------------------------------------------------------------
  // registers
  // --------------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      state_reg <= '0; // blank otp reads as zeros
    end
    else if (ce)
    begin
      state_reg <= state_next;
    end
  end

  assign rdData = state_reg.rdData;

endmodule : fsi_otp_mem

// ===== dv/fsi_integrity_asserts.sv
`timescale 1ns/10ps
// ----------------------------------------------------------------
// port-level checks of the integrity status register
// ----------------------------------------------------------------
module fsi_integrity_asserts #(
  parameter int OTP_DEPTH = 32,
  parameter int INIT_REGS = 4
) (
  input wire logic                         clk,
  input wire logic                         reset,
  input wire logic                         ce,
  input wire logic                         regWrEn,
  input wire logic [15:0]                  regWrData,
  input wire logic [15:0]                  regRdData,
  input wire logic [4:0]                   safety_a,
  input wire logic                         debugEnter,
  input wire logic                         debugActive,
  input wire logic                         leaveDebugPulse,
  input wire logic [INIT_REGS*8-1:0]       init_reg_true_copy,
  input wire logic [INIT_REGS*8-1:0]       init_reg_inverted_copy,
  input wire logic                         otpWrEn,
  input wire logic [$clog2(OTP_DEPTH)-1:0] otpWrAddr,
  input wire logic [7:0]                   otpWrData,
  input wire logic [7:0]                   otpCrcExpected,
  input wire logic                         otpCheckDone
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  // named steps of the leave and shadow sequences
  sequence leave_req;
    ce && regWrEn && regWrData[14];
  endsequence
  sequence shadow_bad;
    ce && (init_reg_true_copy != ~init_reg_inverted_copy);
  endsequence
  a_state_live: assert property (ce |=> regRdData[4:0] == $past(safety_a))
    else $error("state field not live");
  a_dbg_mirror: assert property (regRdData[13] == debugActive)
    else $error("debug bit differs from status");
  a_dbg_enter: assert property (ce && debugEnter && !regWrData[14] |=> debugActive)
    else $error("debug not entered");
  a_dbg_leave: assert property (leave_req |=>
    !debugActive && leaveDebugPulse == $past(debugActive))
    else $error("debug leave wrong");
  a_done_pulse: assert property (otpCheckDone |=> !otpCheckDone[*8])
    else $error("otp check done too soon");
  a_shadow_set: assert property (shadow_bad |=> regRdData[8])
    else $error("shadow mismatch not flagged");
  // a clear may only lose against a compare that fails in the same cycle
  a_otp_wipe: assert property (ce && regWrEn && regWrData[11] |=>
    !regRdData[11] || otpCheckDone)
    else $error("otp flag not cleared");
  a_otp_hold: assert property (regRdData[11] && !(ce && regWrEn && regWrData[11]) |=> regRdData[11])
    else $error("otp flag not sticky");
  a_shadow_hold: assert property (regRdData[8] && !(ce && regWrEn && regWrData[8]) |=> regRdData[8])
    else $error("shadow flag not sticky");
  a_flag_wipe: assert property (ce && regWrEn && regWrData[8] &&
    (init_reg_true_copy == ~init_reg_inverted_copy) |=> !regRdData[8])
    else $error("shadow flag not cleared");
endmodule : fsi_integrity_asserts

bind fsi_integrity fsi_integrity_asserts #(.OTP_DEPTH(OTP_DEPTH), .INIT_REGS(INIT_REGS)) u_chk (
  .clk(clk), .reset(reset), .ce(ce), .regWrEn(regWrEn), .regWrData(regWrData),
  .regRdData(regRdData), .safety_a(safety_a), .debugEnter(debugEnter),
  .debugActive(debugActive), .leaveDebugPulse(leaveDebugPulse),
  .init_reg_true_copy(init_reg_true_copy), .init_reg_inverted_copy(init_reg_inverted_copy),
  .otpWrEn(otpWrEn), .otpWrAddr(otpWrAddr), .otpWrData(otpWrData),
  .otpCrcExpected(otpCrcExpected), .otpCheckDone(otpCheckDone));

// ===== dv/fsi_integrity_bench.sv
`timescale 1ns/10ps
module fsi_integrity_bench;
  // ----------------------------------------------------------------
  // stimulus and dut
  // ----------------------------------------------------------------
  logic        clk, reset, regWrEn, debugEnter, otpWrEn;
  logic [15:0] regWrData, regRdData;
  logic [4:0]  safety_a, otpWrAddr;
  logic [31:0] trueCopy, invCopy;
  logic [7:0]  otpWrData, otpCrcExpected;
  logic        debugActive, leaveDebugPulse, otpCheckDone;
  int          n_errors, total_checks;
  logic        ce;
  // short crc period keeps the run brief
  localparam int PERIOD = 64;
  fsi_integrity #(.CRC_PERIOD_CYCLES(PERIOD)) u_dut (.clk(clk), .reset(reset), .ce(ce),
    .regWrEn(regWrEn), .regWrData(regWrData), .regRdData(regRdData), .safety_a(safety_a),
    .debugEnter(debugEnter), .debugActive(debugActive), .leaveDebugPulse(leaveDebugPulse),
    .init_reg_true_copy(trueCopy), .init_reg_inverted_copy(invCopy), .otpWrEn(otpWrEn),
    .otpWrAddr(otpWrAddr), .otpWrData(otpWrData), .otpCrcExpected(otpCrcExpected),
    .otpCheckDone(otpCheckDone));
  initial
  begin
    clk = 0;
    forever #25 clk = ~clk;
  end
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic stop_test;
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : stop_test
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // inputs change 1 ns after the edge, away from sampling
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  task automatic wr(input logic [15:0] d);
    regWrEn = 1;
    regWrData = d;
    tick(1);
    regWrEn = 0;
    regWrData = 16'h0000;
  endtask : wr
  // bounded wait; gives cycles spent
  task automatic wait_done(output int n);
    for (n = 0; n < 200 && otpCheckDone !== 1'b1; n++) tick(1);
    if (n == 200)
    begin
      n_errors++;
      stop_test();
    end
  endtask : wait_done
  // image is all zero except byte 3
  function automatic logic [7:0] crc_img(input logic [7:0] b3);
    logic [7:0] c;
    c = 8'hFF;
    for (int a = 0; a < 32; a++)
    begin
      c ^= (a == 3) ? b3 : 8'h00;
      repeat (8) c = c[7] ? {c[6:0], 1'b0} ^ 8'h2F : {c[6:0], 1'b0};
    end
    return c;
  endfunction : crc_img
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_otp;
    int n;
    otpWrEn = 1;
    otpWrAddr = 5'h03;
    otpWrData = 8'h5A;
    tick(1);
    otpWrEn = 0;
    otpCrcExpected = crc_img(8'h5A);
    wait_done(n);
    chk(regRdData[11], 1'b0);
    otpCrcExpected = ~crc_img(8'h5A);
    tick(1);
    wait_done(n);
    chk(16'(n + 1), 16'(PERIOD));
    chk(regRdData[11], 1'b1);
    wr(16'h0000);
    chk(regRdData[11], 1'b1);
    tick(1);
    wr(16'h0800);
    chk(regRdData[11], 1'b0);
    otpCrcExpected = crc_img(8'h5A);
    $display("test otp done");
  endtask : t_otp
  task automatic t_shadow;
    invCopy[0] = ~invCopy[0];
    tick(1);
    chk(regRdData[8], 1'b1);
    wr(16'h0100);
    chk(regRdData[8], 1'b1);
    tick(1);
    invCopy = ~trueCopy;
    wr(16'h0000);
    chk(regRdData[8], 1'b1);
    tick(1);
    wr(16'h0100);
    chk(regRdData[8], 1'b0);
    $display("test shadow done");
  endtask : t_shadow
  task automatic t_debug;
    debugEnter = 1;
    tick(1);
    debugEnter = 0;
    chk({debugActive, regRdData[13]}, 2'b11);
    wr(16'h0000);
    chk(debugActive, 1'b1);
    tick(1);
    wr(16'h4000);
    chk({debugActive, leaveDebugPulse, regRdData[13]}, 3'b010);
    tick(1);
    chk(leaveDebugPulse, 1'b0);
    debugEnter = 1;
    wr(16'h4000);
    debugEnter = 0;
    chk({debugActive, leaveDebugPulse}, 2'b00);
    $display("test debug done");
  endtask : t_debug
  task automatic t_state;
    for (int s = 0; s < 32; s++)
    begin
      safety_a = 5'(s);
      tick(1);
      chk(regRdData, {11'h000, 5'(s)});
    end
    $display("test state done");
  endtask : t_state
  // ce low must freeze every register, debug entry included
  task automatic t_freeze;
    tick(1);
    ce = 0;
    debugEnter = 1;
    safety_a = 5'h15;
    tick(2);
    chk(regRdData, 16'h0006);
    chk(debugActive, 1'b0);
    ce = 1;
    debugEnter = 0;
    tick(1);
    chk(regRdData, 16'h0015);
    $display("test freeze done");
  endtask : t_freeze
  // power-on reset mid-run wipes the sticky flags and the otp image
  task automatic t_por;
    int n;
    invCopy[0] = ~invCopy[0];
    tick(1);
    chk(regRdData[8], 1'b1);
    invCopy = ~trueCopy;
    reset = 1;
    tick(1);
    chk(regRdData, 16'h0006);
    reset = 0;
    otpCrcExpected = crc_img(8'h00);
    wait_done(n);
    chk(regRdData, {11'h000, 5'h1F});
    $display("test por done");
  endtask : t_por
  // main sequence, reset held 12 cycles
  initial
  begin
    {reset, regWrEn, regWrData, debugEnter, otpWrEn, otpWrAddr, otpWrData} = '0;
    reset = 1;
    ce = 1;
    safety_a = 5'h06;
    trueCopy = 32'h1234_5678;
    invCopy = ~32'h1234_5678;
    otpCrcExpected = 8'h00;
    n_errors = 0;
    total_checks = 0;
    tick(12);
    chk(regRdData, 16'h0006);
    reset = 0;
    t_otp();
    t_shadow();
    t_debug();
    t_freeze();
    t_state();
    t_por();
    stop_test();
  end
endmodule : fsi_integrity_bench
